// [rtl/ascs_serial.sv]
`timescale 1ns/1ps
`include "ascs_defs.svh"

// Summary of operation
// - All enabled flags share one interrupt, gated by global mask; wakes wait, not halt.
// - tx_empty sets when holding moves to shifter; clears on status then data write.
// - No holding-to-shifter move while tx_empty is set.
// - tx_done sets at end of data, preamble or break frame; same clear.
// - rx_full sets on word transfer; clears on rx_on low or status then data read.
// - Idle flag sets once per rx_full; never from the idle that wakes mute.
// - Overrun on completed word with rx_full set; holding kept, shifter overwritten.
// - noise_flag sets with the word and raises no interrupt itself.
// - framing_err sets on bad stop or break; no interrupt of its own.
// - Framing error plus overrun sets only overrun.
// - rx_on low clears all receive flags; status then data read clears too.
// - Nine-bit words use rx_bit_nine on receive and tx_bit_nine on send.
// - Word length 0 gives 1+8+1 bits, 1 gives 1+9+1 bits.
// - Wake method 0 is idle line, 1 is address mark.
// - tx_empty and tx_done interrupts follow their enables.
// - rx_irq_en requests on overrun or rx_full.
// - idle_irq_en requests on the idle flag.
// - tx_on enables transmitter and hands it the output pin.
// - tx_on toggled off then on sends a preamble after current word.
// - rx_on starts the receiver hunting for a start bit at once.
// - rx_mute mutes; hardware clears it on the chosen wake-up sequence.
// - send_break sends breaks; set then cleared still sends one break.
module ascs_serial (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [4:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [4:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic RXD,
  output logic TXD_O,
  output logic TXD_OE,
  input wire logic IRQ_MASK,
  input wire logic HALT_MODE,
  output logic SERIAL_IRQ,
  output logic WAIT_WAKE
);
  // ****************************************
  // Register bus slave
  // ****************************************
  logic aw_got_q, w_got_q, bvalid_q, rvalid_q, w_lane_q;
  logic [4:0] aw_addr_q;
  logic [7:0] w_data_q, rdata_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_fire, rd_fire;

  function automatic logic ascs_mapped(input logic [4:0] a);
    return a[4] == 1'b0;
  endfunction : ascs_mapped

  function automatic logic [1:0] ascs_resp(input logic [4:0] a);
    return ascs_mapped(a) ? `ASCS_RESP_OK : `ASCS_RESP_ERR;
  endfunction : ascs_resp

  assign S_AXI_AWREADY = !aw_got_q && !bvalid_q;
  assign S_AXI_WREADY = !w_got_q && !bvalid_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = {24'h000000, rdata_q};
  assign wr_fire = aw_got_q && w_got_q;
  assign rd_fire = S_AXI_ARVALID && !rvalid_q;

  // Address and data latch in either order; response once both held
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bvalid_q <= 1'b0;
      aw_addr_q <= 5'h00;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      bresp_q <= `ASCS_RESP_OK;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_got_q <= 1'b1;
        aw_addr_q <= {S_AXI_AWADDR[4:2], 2'b00};
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_got_q <= 1'b1;
        w_data_q <= S_AXI_WDATA[7:0];
        w_lane_q <= S_AXI_WSTRB[0];
      end
      if (wr_fire)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= ascs_resp(aw_addr_q);
      end
      else if (bvalid_q && S_AXI_BREADY)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] ctrl2_q, rx_holding_q, tx_holding_q;
  logic rx_bit_nine_q, tx_bit_nine_q, word_len_q, wake_method_q;
  logic tx_empty_q, tx_done_q, rx_full_q, idle_q, overrun_q, noise_q, framing_err_q;
  logic armed_q, idle_arm_q;
  logic [4:0] ar_addr;
  logic st_rd, dr_rd, dr_wr, c1_wr, c2_wr, clear_tx, clear_rx;
  logic tx_on, rx_on, rx_mute, send_break;

  assign ar_addr = {S_AXI_ARADDR[4:2], 2'b00};
  assign st_rd = rd_fire && (ar_addr == `ASCS_OFS_STATUS);
  assign dr_rd = rd_fire && (ar_addr == `ASCS_OFS_DATA);
  assign dr_wr = wr_fire && w_lane_q && (aw_addr_q == `ASCS_OFS_DATA);
  assign c1_wr = wr_fire && w_lane_q && (aw_addr_q == `ASCS_OFS_CTRL1);
  assign c2_wr = wr_fire && w_lane_q && (aw_addr_q == `ASCS_OFS_CTRL2);
  assign clear_tx = armed_q && dr_wr;
  assign clear_rx = armed_q && dr_rd;
  assign tx_on = ctrl2_q[`ASCS_C2_TE];
  assign rx_on = ctrl2_q[`ASCS_C2_RE];
  assign rx_mute = ctrl2_q[`ASCS_C2_MUTE];
  assign send_break = ctrl2_q[`ASCS_C2_BRK];

  // Clear arming: a status read arms, any later access uses or drops it
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      armed_q <= 1'b0;
    else if (st_rd)
      armed_q <= 1'b1;
    else if (rd_fire || wr_fire)
      armed_q <= 1'b0;
  end

  // Read data path
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= `ASCS_RESP_OK;
    end
    else if (rd_fire)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= ascs_resp(ar_addr);
      unique case (ar_addr)
        `ASCS_OFS_STATUS: rdata_q <= {tx_empty_q, tx_done_q, rx_full_q, idle_q,
                                      overrun_q, noise_q, framing_err_q, 1'b0};
        `ASCS_OFS_DATA: rdata_q <= rx_holding_q;
        `ASCS_OFS_CTRL1: rdata_q <= {rx_bit_nine_q, tx_bit_nine_q, 1'b0, word_len_q,
                                     wake_method_q, 3'b000};
        `ASCS_OFS_CTRL2: rdata_q <= ctrl2_q;
        default: rdata_q <= 8'h00;
      endcase
    end
    else if (S_AXI_RREADY)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // Transmit control
  // ****************************************
  logic tx_on_d_q, brk_d_q, pre_pend_q, brk_pend_q;
  logic eng_busy, eng_done, eng_start, load_data, tx_rise;
  ascs_pkg::ascs_frame_e eng_kind;

  assign tx_rise = tx_on && !tx_on_d_q;

  // Break beats preamble, preamble beats data
  always_comb
  begin
    eng_start = 1'b0;
    eng_kind = ascs_pkg::FR_DATA;
    if (tx_on && !eng_busy)
    begin
      if (send_break || brk_pend_q)
      begin
        eng_start = 1'b1;
        eng_kind = ascs_pkg::FR_BRK;
      end
      else if (pre_pend_q)
      begin
        eng_start = 1'b1;
        eng_kind = ascs_pkg::FR_PRE;
      end
      else if (!tx_empty_q)
      begin
        eng_start = 1'b1;
      end
    end
  end
  assign load_data = eng_start && (eng_kind == ascs_pkg::FR_DATA);

  // Pending preamble on each enable edge, pending break on break release
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      tx_on_d_q <= 1'b0;
      brk_d_q <= 1'b0;
      pre_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
    end
    else
    begin
      tx_on_d_q <= tx_on;
      brk_d_q <= send_break;
      if (tx_rise)
        pre_pend_q <= 1'b1;
      else if (eng_start && eng_kind == ascs_pkg::FR_PRE)
        pre_pend_q <= 1'b0;
      if (brk_d_q && !send_break)
        brk_pend_q <= 1'b1;
      else if (eng_start && eng_kind == ascs_pkg::FR_BRK)
        brk_pend_q <= 1'b0;
    end
  end

  // Transmit flags; set wins over the software clear
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      tx_empty_q <= `ASCS_TXE_RST;
      tx_done_q <= `ASCS_TXD_RST;
      tx_holding_q <= 8'h00;
    end
    else
    begin
      if (dr_wr)
        tx_holding_q <= w_data_q;
      // Re-enable drops the held byte, so it reads as empty
      if (load_data || tx_rise)
        tx_empty_q <= 1'b1;
      else if (clear_tx)
        tx_empty_q <= 1'b0;
      if (eng_done)
        tx_done_q <= 1'b1;
      else if (clear_tx)
        tx_done_q <= 1'b0;
    end
  end

  ascs_tx u_tx (
    .clk(MCLK),
    .rst(SYS_RST),
    .start(eng_start),
    .kind(eng_kind),
    .word({tx_bit_nine_q && word_len_q, tx_holding_q}),
    .nine(word_len_q),
    .busy(eng_busy),
    .done(eng_done),
    .txd(TXD_O)
  );
  // Pin belongs to the port logic while the transmitter is off
  assign TXD_OE = tx_on;

  // ****************************************
  // Control registers
  // ****************************************
  logic fr_end, addr_wake, idle_evt, idle_wake;

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      ctrl2_q <= `ASCS_CTRL2_RST;
      tx_bit_nine_q <= `ASCS_CTRL1_RST;
      word_len_q <= `ASCS_CTRL1_RST;
      wake_method_q <= `ASCS_CTRL1_RST;
    end
    else
    begin
      if (c1_wr)
      begin
        tx_bit_nine_q <= w_data_q[`ASCS_C1_TX9];
        word_len_q <= w_data_q[`ASCS_C1_LEN];
        wake_method_q <= w_data_q[`ASCS_C1_WAKE];
      end
      if (c2_wr)
        ctrl2_q <= w_data_q;
      else if (idle_wake || addr_wake)
        ctrl2_q[`ASCS_C2_MUTE] <= 1'b0;
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  ascs_pkg::ascs_rx_e rx_st_q;
  logic rxd_s1_q, rxd_s2_q, noise_acc_q, vote, disagree;
  logic [7:0] cyc_q;
  logic [3:0] bit_q, ones_q;
  logic [8:0] word_q, fr_word;
  logic [1:0] smp_q;
  logic fr_msb, accept, xfer, ovr_evt;

  // Two-stage synchroniser on the receive pin
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
    end
    else
    begin
      rxd_s1_q <= RXD;
      rxd_s2_q <= rxd_s1_q;
    end
  end

  // Three samples at the bit centre; any split counts as noise
  assign vote = (smp_q[1] & smp_q[0]) | (smp_q[1] & rxd_s2_q) | (smp_q[0] & rxd_s2_q);
  assign disagree = !((smp_q[1] == smp_q[0]) && (smp_q[0] == rxd_s2_q));
  assign fr_end = (rx_st_q == ascs_pkg::RX_STOP) && (cyc_q == 8'h00);
  assign fr_word = word_len_q ? word_q : {1'b0, word_q[8:1]};
  assign fr_msb = word_len_q ? fr_word[8] : fr_word[7];
  assign addr_wake = fr_end && rx_mute && wake_method_q && fr_msb;
  assign accept = fr_end && (!rx_mute || addr_wake);
  assign xfer = accept && !rx_full_q;
  assign ovr_evt = accept && rx_full_q;
  assign idle_evt = (rx_st_q == ascs_pkg::RX_HUNT)
                    && (ones_q == ascs_pkg::ascs_frame_len(word_len_q))
                    && (cyc_q == 8'h00) && rxd_s2_q;
  assign idle_wake = idle_evt && rx_mute && !wake_method_q;

  // Bit timing and framing; idle counted in whole frames of high line
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST || !rx_on)
    begin
      rx_st_q <= ascs_pkg::RX_HUNT;
      cyc_q <= `ASCS_BIT_CYC - 8'h01;
      bit_q <= 4'h0;
      ones_q <= 4'h0;
      word_q <= 9'h000;
      smp_q <= 2'b11;
      noise_acc_q <= 1'b0;
    end
    else
    begin
      if (cyc_q == 8'h02 || cyc_q == 8'h01)
        smp_q <= {smp_q[0], rxd_s2_q};
      unique case (rx_st_q)
        ascs_pkg::RX_HUNT:
        begin
          if (!rxd_s2_q)
          begin
            rx_st_q <= ascs_pkg::RX_START;
            cyc_q <= `ASCS_HALF_CYC - 8'h01;
            ones_q <= 4'h0;
          end
          else if (cyc_q == 8'h00)
          begin
            cyc_q <= `ASCS_BIT_CYC - 8'h01;
            if (ones_q != 4'hf)
              ones_q <= idle_evt ? 4'hf : ones_q + 4'h1;
          end
          else
            cyc_q <= cyc_q - 8'h01;
        end
        ascs_pkg::RX_START:
        begin
          if (cyc_q != 8'h00)
            cyc_q <= cyc_q - 8'h01;
          else if (rxd_s2_q)
            rx_st_q <= ascs_pkg::RX_HUNT;
          else
          begin
            rx_st_q <= ascs_pkg::RX_DATA;
            cyc_q <= `ASCS_BIT_CYC - 8'h01;
            bit_q <= 4'h0;
            noise_acc_q <= 1'b0;
          end
        end
        ascs_pkg::RX_DATA:
        begin
          if (cyc_q != 8'h00)
            cyc_q <= cyc_q - 8'h01;
          else
          begin
            word_q <= {vote, word_q[8:1]};
            noise_acc_q <= noise_acc_q | disagree;
            bit_q <= bit_q + 4'h1;
            cyc_q <= `ASCS_BIT_CYC - 8'h01;
            if (bit_q == ascs_pkg::ascs_frame_len(word_len_q) - 4'h3)
              rx_st_q <= ascs_pkg::RX_STOP;
          end
        end
        ascs_pkg::RX_STOP:
        begin
          if (cyc_q != 8'h00)
            cyc_q <= cyc_q - 8'h01;
          else
          begin
            rx_st_q <= ascs_pkg::RX_HUNT;
            cyc_q <= `ASCS_BIT_CYC - 8'h01;
          end
        end
        default: rx_st_q <= ascs_pkg::RX_HUNT;
      endcase
    end
  end

  // Receive flags; receiver off clears them all, set wins over clear
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST || !rx_on)
    begin
      rx_full_q <= 1'b0;
      idle_q <= 1'b0;
      overrun_q <= 1'b0;
      noise_q <= 1'b0;
      framing_err_q <= 1'b0;
    end
    else
    begin
      if (xfer)
        rx_full_q <= 1'b1;
      else if (clear_rx)
        rx_full_q <= 1'b0;
      if (ovr_evt)
        overrun_q <= 1'b1;
      else if (clear_rx)
        overrun_q <= 1'b0;
      if (xfer && (noise_acc_q || disagree))
        noise_q <= 1'b1;
      else if (clear_rx)
        noise_q <= 1'b0;
      // Only a transferred word can flag framing, never an overrun one
      if (xfer && !vote)
        framing_err_q <= 1'b1;
      else if (clear_rx)
        framing_err_q <= 1'b0;
      if (idle_evt && !rx_mute && idle_arm_q)
        idle_q <= 1'b1;
      else if (clear_rx)
        idle_q <= 1'b0;
    end
  end

  // Holding keeps its word on overrun; idle re-arms on each new word
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      rx_holding_q <= 8'h00;
      rx_bit_nine_q <= 1'b0;
      idle_arm_q <= 1'b1;
    end
    else
    begin
      if (xfer)
      begin
        rx_holding_q <= fr_word[7:0];
        rx_bit_nine_q <= word_len_q & fr_word[8];
        idle_arm_q <= 1'b1;
      end
      else if (idle_evt && !rx_mute && rx_on)
        idle_arm_q <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt request
  // ****************************************
  logic irq_req;
  assign irq_req = (ctrl2_q[`ASCS_C2_TIE] && tx_empty_q)
                   || (ctrl2_q[`ASCS_C2_TX_DONE_IRQ_EN] && tx_done_q)
                   || (ctrl2_q[`ASCS_C2_RIE] && (rx_full_q || overrun_q))
                   || (ctrl2_q[`ASCS_C2_IDLE_IRQ_EN] && idle_q);

  // Registered so the pin never glitches on flag updates
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      SERIAL_IRQ <= 1'b0;
      WAIT_WAKE <= 1'b0;
    end
    else
    begin
      SERIAL_IRQ <= irq_req && !IRQ_MASK;
      WAIT_WAKE <= irq_req && !IRQ_MASK && !HALT_MODE;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);

  // Status read, bus quiet while its answer drains, then the data access
  sequence s_arm_wr;
    st_rd ##1 (!rd_fire && !wr_fire)[*3] ##1 (dr_wr && !eng_done && !load_data && !tx_rise);
  endsequence
  sequence s_arm_rd;
    st_rd ##1 (!rd_fire && !wr_fire)[*2] ##1 (dr_rd && !xfer);
  endsequence

  irq_mask_a: assert property (IRQ_MASK |=> !SERIAL_IRQ && !WAIT_WAKE)
    else $error("interrupt seen while masked");
  irq_txe_a: assert property ((ctrl2_q[`ASCS_C2_TIE] && tx_empty_q && !IRQ_MASK) |=>
                              SERIAL_IRQ)
    else $error("tx empty interrupt missing");
  irq_rx_a: assert property ((ctrl2_q[`ASCS_C2_RIE] && overrun_q && !IRQ_MASK) |=>
                             SERIAL_IRQ)
    else $error("overrun interrupt missing");
  irq_idle_a: assert property ((ctrl2_q[`ASCS_C2_IDLE_IRQ_EN] && idle_q && !IRQ_MASK) |=>
                               SERIAL_IRQ)
    else $error("idle interrupt missing");
  err_noirq_a: assert property ((ctrl2_q[7:4] == 4'b0010 && !rx_full_q && !overrun_q) |=>
                                !SERIAL_IRQ)
    else $error("error flag raised interrupt");
  tx_load_a: assert property (load_data |-> !tx_empty_q ##1 tx_empty_q)
    else $error("holding moved while empty");
  tx_done_a: assert property (eng_done |=> tx_done_q)
    else $error("tx done not set");
  tx_clear_a: assert property (s_arm_wr |=> !tx_empty_q && !tx_done_q)
    else $error("tx clear sequence failed");
  rx_clear_a: assert property (s_arm_rd |=> !rx_full_q)
    else $error("rx clear sequence failed");
  rx_keep_a: assert property ((ovr_evt && rx_on && !clear_rx) |=> overrun_q
                              && $stable(rx_holding_q) && $stable(framing_err_q))
    else $error("overrun altered holding");
  rx_off_a: assert property (!rx_on |=> !(rx_full_q || idle_q || overrun_q || noise_q
                                          || framing_err_q))
    else $error("flags survive receiver off");
  mute_wake_a: assert property ((idle_wake && !c2_wr) |=> !rx_mute && !$rose(idle_q))
    else $error("idle wake mishandled");
endmodule : ascs_serial

// [rtl/ascs_defs.svh]
`ifndef ASCS_DEFS_SVH
`define ASCS_DEFS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define ASCS_OFS_STATUS 5'h00
`define ASCS_OFS_DATA 5'h04
`define ASCS_OFS_CTRL1 5'h08
`define ASCS_OFS_CTRL2 5'h0c
// ****************************************
// Field positions and reset values
// ****************************************
`define ASCS_ST_TXE 7
`define ASCS_ST_TXD 6
`define ASCS_ST_RXF 5
`define ASCS_ST_IDLE 4
`define ASCS_ST_OVR 3
`define ASCS_ST_NOISE 2
`define ASCS_ST_FERR 1
`define ASCS_C1_RX9 7
`define ASCS_C1_TX9 6
`define ASCS_C1_LEN 4
`define ASCS_C1_WAKE 3
`define ASCS_C2_TIE 7
`define ASCS_C2_TX_DONE_IRQ_EN 6
`define ASCS_C2_RIE 5
`define ASCS_C2_IDLE_IRQ_EN 4
`define ASCS_C2_TE 3
`define ASCS_C2_RE 2
`define ASCS_C2_MUTE 1
`define ASCS_C2_BRK 0
`define ASCS_STATUS_RST 8'hc0
`define ASCS_TXE_RST 1'b1
`define ASCS_TXD_RST 1'b1
`define ASCS_CTRL1_RST 1'b0
`define ASCS_CTRL2_RST 8'h00
// ****************************************
// Framing, timing and bus responses
// ****************************************
`define ASCS_FRAME8 4'ha
`define ASCS_FRAME9 4'hb
`define ASCS_BIT_CYC 8'h10
`define ASCS_HALF_CYC 8'h08
`define ASCS_RESP_OK 2'b00
`define ASCS_RESP_ERR 2'b10
`endif

// [rtl/ascs_pkg.sv]
`include "ascs_defs.svh"
package ascs_pkg;
  typedef enum logic [3:0] {
    RX_HUNT = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } ascs_rx_e;
  typedef enum logic [2:0] {
    FR_DATA = 3'b001,
    FR_PRE = 3'b010,
    FR_BRK = 3'b100
  } ascs_frame_e;
  // Bits in one frame, start and stop included
  function automatic logic [3:0] ascs_frame_len(input logic nine);
    return nine ? `ASCS_FRAME9 : `ASCS_FRAME8;
  endfunction : ascs_frame_len
endpackage : ascs_pkg

// [rtl/ascs_tx.sv]
`timescale 1ns/1ps
`include "ascs_defs.svh"
module ascs_tx (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire ascs_pkg::ascs_frame_e kind,
  input wire logic [8:0] word,
  input wire logic nine,
  output logic busy,
  output logic done,
  output logic txd
);
  logic [10:0] shift_q;
  logic [3:0] left_q;
  logic [7:0] cyc_q;
  logic [10:0] frame;

  // Frame image, bit 0 leaves first
  always_comb
  begin
    unique case (kind)
      ascs_pkg::FR_DATA: frame = nine ? {1'b1, word, 1'b0} : {2'b11, word[7:0], 1'b0};
      ascs_pkg::FR_BRK: frame = 11'h000;
      ascs_pkg::FR_PRE: frame = 11'h7ff;
      default: frame = 11'h7ff;
    endcase
  end

  assign busy = (left_q != 4'h0);
  assign txd = shift_q[0];
  // Last bit period over
  assign done = busy && (cyc_q == 8'h00) && (left_q == 4'h1);

  // Shifter fills with ones, so the line idles high; an 8-bit break leaves it low until the next frame
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      shift_q <= 11'h7ff;
      left_q <= 4'h0;
      cyc_q <= 8'h00;
    end
    else if (start && !busy)
    begin
      shift_q <= frame;
      left_q <= ascs_pkg::ascs_frame_len(nine);
      cyc_q <= `ASCS_BIT_CYC - 8'h01;
    end
    else if (busy)
    begin
      if (cyc_q == 8'h00)
      begin
        shift_q <= {1'b1, shift_q[10:1]};
        left_q <= left_q - 4'h1;
        cyc_q <= `ASCS_BIT_CYC - 8'h01;
      end
      else
      begin
        cyc_q <= cyc_q - 8'h01;
      end
    end
  end
endmodule : ascs_tx

// [testbench/ascs_remote.sv]
`timescale 1ns/1ps
`include "ascs_defs.svh"
// ****
// Remote station
// ****
module ascs_remote (
  input wire logic MCLK,
  input wire logic TXD,
  output logic RXD
);
  logic [7:0] got_q;
  int n_got = 0;
  initial RXD = 1'b1;
  // Frame out, LSB first; stop level chosen to force faults
  task send(input logic [7:0] w, input logic stp);
    logic [9:0] f;
    f = {stp, w, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      RXD <= f[i];
      repeat (`ASCS_BIT_CYC) @(posedge MCLK);
    end
    RXD <= 1'b1;
  endtask : send
  // Mid-bit decode; preambles have no start edge
  initial
  forever
  begin
    @(negedge TXD);
    repeat (`ASCS_HALF_CYC) @(posedge MCLK);
    for (int i = 0; i < 8; i++)
    begin
      repeat (`ASCS_BIT_CYC) @(posedge MCLK);
      got_q[i] = TXD;
    end
    repeat (`ASCS_BIT_CYC) @(posedge MCLK);
    n_got++;
  end
endmodule : ascs_remote

// [testbench/async_serial_status_control_tb.sv]
`timescale 1ns/1ps
module async_serial_status_control_tb;
  logic mclk, rst, awv, wv, br, arv, rr, msk, awr, wrd, bv, arr, rv, txd, oe, irq, rxd, hlt, wk;
  logic [4:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0] bre, rre, rs, ws;
  logic [7:0] b, b2, v;
  int n_errors, n_compared, k, seed, cyc = 0;
  ascs_serial u_ascs_serial (.MCLK(mclk), .SYS_RST(rst), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bre), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rre), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
    .RXD(rxd), .TXD_O(txd), .TXD_OE(oe), .IRQ_MASK(msk), .HALT_MODE(hlt),
    .SERIAL_IRQ(irq), .WAIT_WAKE(wk));
  ascs_remote u_ascs_remote (.MCLK(mclk), .TXD(txd), .RXD(rxd));
  // ****
  // Bus tasks and checks
  // ****
  task wr(input logic [4:0] a, input logic [7:0] d);
    logic ta, tw, t;
    awa <= a; wd <= {24'h0, d}; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin @(negedge mclk); ta = awr & awv; tw = wrd & wv; @(posedge mclk);
      if (ta) awv <= 1'b0; if (tw) wv <= 1'b0; t = (awv & ~ta) | (wv & ~tw); end
    while (t);
    do begin @(negedge mclk); t = bv; ws = bre; @(posedge mclk); end while (!t);
    br <= 1'b0; @(posedge mclk);
  endtask : wr
  task rd(input logic [4:0] a, output logic [7:0] d);
    logic t;
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin @(negedge mclk); t = arr; @(posedge mclk); end while (!t);
    arv <= 1'b0;
    do begin @(negedge mclk); t = rv; d = rdat[7:0]; rs = rre; @(posedge mclk); end
    while (!t);
    rr <= 1'b0; @(posedge mclk);
  endtask : rd
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin n_errors++; $display("Error %s expected %h seen %h", nm, e, g); end
  endtask : chk
  // Receive flags as the status word shows them
  function automatic logic [7:0] st(input logic f, input logic o, input logic e);
    return {2'b00, f, 1'b0, o, 1'b0, e, 1'b0};
  endfunction : st
  task complete_run;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // Clock, 4 ns period
  initial begin mclk = 1'b0; forever #2 mclk = ~mclk; end
  // Hang guard, well above the run length
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end
  // ****
  // Main sequence
  // ****
  initial
  begin
    seed = 32'hade0; rst = 1'b1; awv = 0; wv = 0; br = 0; arv = 0; rr = 0; msk = 0; hlt = 0;
    awa = 0; ara = 0; wd = 0; n_errors = 0; n_compared = 0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0; @(posedge mclk);
    rd(5'h00, v); chk("status", 8'hc0, v);
    rd(5'h0c, v); chk("ctrl2", 8'h00, v);
    rd(5'h10, v); chk("rresp", 8'h02, {6'h0, rs});
    wr(5'h10, 8'hff); chk("bresp", 8'h02, {6'h0, ws});
    wr(5'h0c, 8'h2c); chk("oe", 8'h01, {7'h0, oe});
    chk("bresp", 8'h00, {6'h0, ws});
    repeat (200) @(posedge mclk);
    $display("test reset done");
    repeat (3)
    begin
      b = $random(seed); k = u_ascs_remote.n_got;
      rd(5'h00, v); wr(5'h04, b);
      for (int i = 0; i < 400 && u_ascs_remote.n_got == k; i++) @(posedge mclk);
      chk("txd", b, u_ascs_remote.got_q);
      b = $random(seed); u_ascs_remote.send(b, 1'b1); repeat (40) @(posedge mclk);
      chk("irq", 8'h01, {7'h0, irq});
      rd(5'h00, v); chk("rxst", st(1, 0, 0), v & 8'h2e);
      rd(5'h04, v); chk("rxd", b, v);
      rd(5'h00, v); chk("clr", st(0, 0, 0), v & 8'h2e);
    end
    $display("test traffic done");
    // Second word lands on a full holding; bad stop must not flag framing
    b = 8'($random(seed));
    b2 = 8'($random(seed));
    u_ascs_remote.send(b, 1'b1);
    repeat (16) @(posedge mclk);
    u_ascs_remote.send(b2, 1'b0);
    repeat (40) @(posedge mclk);
    rd(5'h00, v); chk("ovrst", st(1, 1, 0), v & 8'h2e);
    rd(5'h04, v); chk("ovrdat", b, v);
    rd(5'h00, v); chk("ovrclr", st(0, 0, 0), v & 8'h2e);
    $display("test overrun done");
    // Empty holding with its enable set requests service; mask gates it, halt gates only the wake
    wr(5'h0c, 8'hac);
    repeat (3) @(posedge mclk);
    chk("irq", 8'h01, {7'h0, irq});
    chk("wake", 8'h01, {7'h0, wk});
    msk <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("mirq", 8'h00, {7'h0, irq});
    chk("mwake", 8'h00, {7'h0, wk});
    msk <= 1'b0;
    hlt <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("hirq", 8'h01, {7'h0, irq});
    chk("hwake", 8'h00, {7'h0, wk});
    $display("test mask done");
    complete_run();
  end
endmodule : async_serial_status_control_tb
